// >>> logic/cmpis_top.sv
// Purpose: comparator input routing, edge interrupt and pin input disable control
// Assumes: Avalon-MM slave with waitrequest, analog comparator result arrives asynchronously
// Notes: every access completes with waitrequest low one ce-enabled cycle after the request appears
`timescale 1ns/1ps

module cmpis_top
    import cmpis_pkg::*;
(
    // clock, reset, freeze
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    // register bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // analog front end
    input wire logic cmp_raw,
    input wire logic converter_enable,
    output cmpis_pos_type pos_sel,
    output cmpis_neg_type neg_sel,
    // port pins
    input wire logic [7:0] pin_level,
    output logic [7:0] buffer_disable,
    output logic [7:0] port_read,
    // core interrupt
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    output logic comparator_irq_req,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] ctrl_r;
    logic [7:0] csb_r;
    logic [7:0] mux_r;
    logic [7:0] did_r;
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [2:0] mask_r;
    logic irq_flag_r;
    logic irq_flag_nxt;
    logic cmp_prev_r;
    logic ref_bad_prev_r;
    logic chan_bad_prev_r;
    logic done_r;
    logic [7:0] readdata_r;
    logic [7:0] port_read_r;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req = read | write;
    wire fire = req & done_r & ce;
    wire wr_fire = fire & write & byteenable[0];
    wire rd_fire = fire & read;
    wire sel_ctrl = (address == CMPIS_OFF_CTRL);
    wire sel_csb = (address == CMPIS_OFF_CSB);
    wire sel_mux = (address == CMPIS_OFF_MUX);
    wire sel_did = (address == CMPIS_OFF_DID);
    wire sel_stat = (address == CMPIS_OFF_STAT);
    wire sel_mask = (address == CMPIS_OFF_MASK);
    wire [7:0] wbyte = writedata[7:0];

    // one wait cycle, then the access completes at the next enabled edge
    assign waitrequest = req & ~(done_r & ce);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // comparator result and edge events
    logic cmp_sync;

    cmpis_sync u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .d_in(cmp_raw),
        .q_out(cmp_sync)
    );

    wire [1:0] mode_field = ctrl_r[CMPIS_CS_MODE_HI:CMPIS_CS_MODE_LO];
    wire edge_rise = cmp_sync & ~cmp_prev_r;
    wire edge_fall = ~cmp_sync & cmp_prev_r;
    logic cmp_event;

    always_comb
    begin
        unique case (cmpis_mode_type'(mode_field))
            CMPIS_MODE_TOGGLE: cmp_event = edge_rise | edge_fall;
            CMPIS_MODE_RSVD: cmp_event = 1'b0;
            CMPIS_MODE_FALL: cmp_event = edge_fall;
            CMPIS_MODE_RISE: cmp_event = edge_rise;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // input routing
    wire mux_route_enable = csb_r[CMPIS_CSB_MUXEN];
    wire [4:0] channel_select = mux_r[CMPIS_MUX_CHAN_HI:CMPIS_MUX_CHAN_LO];
    wire [1:0] reference_source_select = mux_r[CMPIS_MUX_REFS_HI:CMPIS_MUX_REFS_LO];
    wire internal_ref_select = ctrl_r[CMPIS_CS_IRS];
    wire route_active = mux_route_enable & ~converter_enable;
    wire chan_in_range = (channel_select <= CMPIS_CHAN_MAX);
    wire ref_bad = internal_ref_select & (reference_source_select != CMPIS_REFS_INT);
    wire chan_bad = route_active & ~chan_in_range;

    assign pos_sel.from_pin = ~route_active;
    assign pos_sel.chan_valid = route_active & chan_in_range;
    assign pos_sel.chan = channel_select;
    assign neg_sel.from_pin = ~internal_ref_select;
    assign neg_sel.ref_ok = internal_ref_select & ~ref_bad;
    assign neg_sel.div = csb_r[CMPIS_CSB_DIV_HI:CMPIS_CSB_DIV_LO];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // pin input buffers
    assign buffer_disable = did_r;
    assign port_read = port_read_r;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // comparator flag: set wins over both clears
    wire flag_w1c = wr_fire & sel_ctrl & wbyte[CMPIS_CS_FLAG];
    assign irq_flag_nxt = cmp_event | (irq_flag_r & ~vector_ack & ~flag_w1c);
    assign comparator_irq_req = irq_flag_r & ctrl_r[CMPIS_CS_IE] & global_irq_enable;

    // sticky event status; a read clears only the bits it reported, so an event
    // landing between data capture and completion is not lost; new events win
    wire [2:0] ev_set;
    wire [2:0] stat_clr = (rd_fire & sel_stat) ? readdata_r[2:0] : 3'h0;
    assign ev_set[CMPIS_EV_CMP] = cmp_event;
    assign ev_set[CMPIS_EV_REF] = ref_bad & ~ref_bad_prev_r;
    assign ev_set[CMPIS_EV_CHAN] = chan_bad & ~chan_bad_prev_r;
    assign stat_nxt = ev_set | (stat_r & ~stat_clr);
    assign irq = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_ctrl)
            rd_mux = {1'b0, ctrl_r[6], cmp_sync, irq_flag_r, ctrl_r[3], 1'b0, ctrl_r[1:0]};
        else if (sel_csb)
            rd_mux = {1'b0, csb_r[6:4], 4'h0};
        else if (sel_mux)
            rd_mux = {mux_r[7:6], 1'b0, mux_r[4:0]};
        else if (sel_did)
            rd_mux = did_r;
        else if (sel_stat)
            rd_mux = {5'h00, stat_r};
        else if (sel_mask)
            rd_mux = {5'h00, mask_r};
    end

    assign readdata = {24'h0000_00, readdata_r};

    ////////////////////////////////////////////////////////////////////////////////////////////
    // bus handshake and read data
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            done_r <= 1'b0;
            readdata_r <= 8'h00;
        end
        else if (ce)
        begin
            done_r <= req & ~done_r;
            readdata_r <= (req & ~done_r) ? rd_mux : readdata_r;
        end
    end

    // control registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= CMPIS_RST_CTRL;
            csb_r <= CMPIS_RST_CSB;
            mux_r <= CMPIS_RST_MUX;
            did_r <= CMPIS_RST_DID;
            mask_r <= CMPIS_RST_EV;
        end
        else if (wr_fire)
        begin
            // status and flag bits of the control word are not stored here
            if (sel_ctrl)
                ctrl_r <= {1'b0, wbyte[6], 2'b00, wbyte[3], 1'b0, wbyte[1:0]};
            if (sel_csb)
                csb_r <= {1'b0, wbyte[6:4], 4'h0};
            if (sel_mux)
                mux_r <= {wbyte[7:6], 1'b0, wbyte[4:0]};
            if (sel_did)
                did_r <= wbyte;
            if (sel_mask)
                mask_r <= wbyte[2:0];
        end
    end

    // event tracking
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmp_prev_r <= 1'b0;
            ref_bad_prev_r <= 1'b0;
            chan_bad_prev_r <= 1'b0;
            irq_flag_r <= 1'b0;
            stat_r <= CMPIS_RST_EV;
            port_read_r <= 8'h00;
        end
        else if (ce)
        begin
            cmp_prev_r <= cmp_sync;
            ref_bad_prev_r <= ref_bad;
            chan_bad_prev_r <= chan_bad;
            irq_flag_r <= irq_flag_nxt;
            stat_r <= stat_nxt;
            port_read_r <= pin_level & ~did_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_rsvd_mode;
        @(posedge mclk) disable iff (!nrst)
        (mode_field == CMPIS_MODE_RSVD) |-> !cmp_event;
    endproperty
    a_rsvd_mode: assert property (p_rsvd_mode) else $error("reserved mode made an event");

    property p_rise_mode;
        @(posedge mclk) disable iff (!nrst)
        (ce && mode_field == CMPIS_MODE_RISE && cmp_sync && !cmp_prev_r) |=> irq_flag_r;
    endproperty
    a_rise_mode: assert property (p_rise_mode) else $error("rising edge missed the flag");

    property p_fall_mode;
        @(posedge mclk) disable iff (!nrst)
        (mode_field == CMPIS_MODE_FALL && cmp_sync) |-> !cmp_event;
    endproperty
    a_fall_mode: assert property (p_fall_mode) else $error("falling mode fired on high");

    property p_pin_zero;
        @(posedge mclk) disable iff (!nrst)
        (ce && did_r[CMPIS_DID_POS])
            |-> buffer_disable[CMPIS_DID_POS] ##1 !port_read[CMPIS_DID_POS];
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read nonzero");

    property p_pos_pin;
        @(posedge mclk) disable iff (!nrst)
        (!mux_route_enable || converter_enable) |-> pos_sel.from_pin && !pos_sel.chan_valid;
    endproperty
    a_pos_pin: assert property (p_pos_pin) else $error("positive pin not selected");

    property p_pos_chan;
        @(posedge mclk) disable iff (!nrst)
        (mux_route_enable && !converter_enable)
            |-> !pos_sel.from_pin && (pos_sel.chan_valid == (pos_sel.chan <= 5'h0a));
    endproperty
    a_pos_chan: assert property (p_pos_chan) else $error("channel routing wrong");

    property p_neg_sel;
        @(posedge mclk) disable iff (!nrst)
        neg_sel.from_pin == !ctrl_r[6];
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("negative input source wrong");

    property p_sync_lat;
        @(posedge mclk) disable iff (!nrst)
        ($past(ce, 1) && $past(ce, 2) && $past(nrst, 2)) |-> (cmp_sync == $past(cmp_raw, 2));
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("sync latency not two");

    sequence s_flag_clear;
        ce && irq_flag_r && vector_ack && !cmp_event;
    endsequence

    property p_flag_clear;
        @(posedge mclk) disable iff (!nrst)
        s_flag_clear |=> !irq_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("vector did not clear flag");

    property p_irq_gate;
        @(posedge mclk) disable iff (!nrst)
        (!global_irq_enable || !ctrl_r[CMPIS_CS_IE]) |-> !comparator_irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

endmodule : cmpis_top

// >>> include/cmpis_pkg.sv
// Purpose: shared constants and types for the comparator input and interrupt select block
// Assumes: 8-bit registers, one per aligned 32-bit word on the register bus
// Notes: byte offsets, field positions and reset values are named here; the cmpis_top read mux and register writes also hard-code field bit positions
package cmpis_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] CMPIS_OFF_CTRL = 5'h00;
    localparam logic [4:0] CMPIS_OFF_CSB = 5'h04;
    localparam logic [4:0] CMPIS_OFF_MUX = 5'h08;
    localparam logic [4:0] CMPIS_OFF_DID = 5'h0c;
    localparam logic [4:0] CMPIS_OFF_STAT = 5'h10;
    localparam logic [4:0] CMPIS_OFF_MASK = 5'h14;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // comparator_ctrl_status fields
    localparam int unsigned CMPIS_CS_IRS = 6;
    localparam int unsigned CMPIS_CS_OUT = 5;
    localparam int unsigned CMPIS_CS_FLAG = 4;
    localparam int unsigned CMPIS_CS_IE = 3;
    localparam int unsigned CMPIS_CS_MODE_HI = 1;
    localparam int unsigned CMPIS_CS_MODE_LO = 0;

    // converter_ctrl_status_b fields
    localparam int unsigned CMPIS_CSB_MUXEN = 6;
    localparam int unsigned CMPIS_CSB_DIV_HI = 5;
    localparam int unsigned CMPIS_CSB_DIV_LO = 4;

    // converter_mux_reg fields
    localparam int unsigned CMPIS_MUX_REFS_HI = 7;
    localparam int unsigned CMPIS_MUX_REFS_LO = 6;
    localparam int unsigned CMPIS_MUX_CHAN_HI = 4;
    localparam int unsigned CMPIS_MUX_CHAN_LO = 0;

    // digital_input_disable_0 fields
    localparam int unsigned CMPIS_DID_POS = 7;
    localparam int unsigned CMPIS_DID_NEG = 6;

    // event status and mask fields
    localparam int unsigned CMPIS_EV_CMP = 0;
    localparam int unsigned CMPIS_EV_REF = 1;
    localparam int unsigned CMPIS_EV_CHAN = 2;
    localparam int unsigned CMPIS_EV_W = 3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CMPIS_RST_CTRL = 8'h00;
    localparam logic [7:0] CMPIS_RST_CSB = 8'h00;
    localparam logic [7:0] CMPIS_RST_MUX = 8'h00;
    localparam logic [7:0] CMPIS_RST_DID = 8'h00;
    localparam logic [2:0] CMPIS_RST_EV = 3'h0;

    // codes and counts
    localparam logic [4:0] CMPIS_CHAN_MAX = 5'h0a;
    localparam logic [1:0] CMPIS_REFS_INT = 2'h3;
    localparam int unsigned CMPIS_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        CMPIS_MODE_TOGGLE = 2'b00,
        CMPIS_MODE_RSVD = 2'b01,
        CMPIS_MODE_FALL = 2'b10,
        CMPIS_MODE_RISE = 2'b11
    } cmpis_mode_type;

    // positive input routing to the analog front end
    typedef struct packed {
        logic from_pin;
        logic chan_valid;
        logic [4:0] chan;
    } cmpis_pos_type;

    // negative input routing to the analog front end
    typedef struct packed {
        logic from_pin;
        logic ref_ok;
        logic [1:0] div;
    } cmpis_neg_type;

endpackage : cmpis_pkg

// >>> logic/cmpis_sync.sv
// Purpose: two-flop synchroniser for the raw comparator level
// Assumes: single clock, clock enable freezes both stages
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module cmpis_sync
    import cmpis_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    // level in and out
    input wire logic d_in,
    output logic q_out
);

    logic [CMPIS_SYNC_STAGES-1:0] stage_r;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            stage_r <= '0;
        else if (ce)
            stage_r <= {stage_r[CMPIS_SYNC_STAGES-2:0], d_in};
    end

    assign q_out = stage_r[CMPIS_SYNC_STAGES-1];

endmodule : cmpis_sync

// >>> tb/cmpis_tb_top.sv
// Purpose: self-checking bench for the comparator input and interrupt select block
// Assumes: one clock, ce held high, bus requests held until waitrequest is seen low
// Notes: pin levels, disable masks and the converter enable come from a fixed-seed xorshift; channel and reference codes are swept
`timescale 1ns/1ps
module cmpis_tb_top
    import cmpis_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst, ce, read, write, cmp_raw, converter_enable, global_irq_enable, vector_ack;
    logic waitrequest, comparator_irq_req, irq;
    logic [4:0] address;
    logic [4:0] offs [6];
    logic [31:0] writedata, readdata;
    logic [31:0] seed = 32'h0000_3334;
    logic [3:0] byteenable;
    logic [7:0] pin_level, buffer_disable, port_read, rd, v;
    cmpis_pos_type pos_sel;
    cmpis_neg_type neg_sel;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    cmpis_top dut (.mclk(mclk), .nrst(nrst), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cmp_raw(cmp_raw), .converter_enable(converter_enable),
        .pos_sel(pos_sel), .neg_sel(neg_sel), .pin_level(pin_level),
        .buffer_disable(buffer_disable), .port_read(port_read),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .comparator_irq_req(comparator_irq_req), .irq(irq));

    ////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    // a stuck handshake must not hang the run
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // reserved mode code must never flag an event
    function automatic logic exp_flag(input logic [1:0] md, input logic rise);
        case (md)
            CMPIS_MODE_TOGGLE: return 1'b1;
            CMPIS_MODE_FALL: return !rise;
            CMPIS_MODE_RISE: return rise;
            default: return 1'b0;
        endcase
    endfunction : exp_flag

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // read data is taken in the cycle whose closing edge sees waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h00_0000, d};
        byteenable <= be;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
        cmp_raw = 1'b0;
        converter_enable = 1'b0;
        global_irq_enable = 1'b0;
        vector_ack = 1'b0;
        pin_level = 8'h00;
        offs = '{CMPIS_OFF_CTRL, CMPIS_OFF_CSB, CMPIS_OFF_MUX, CMPIS_OFF_DID,
            CMPIS_OFF_STAT, CMPIS_OFF_MASK};
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 8'h00, 4'hf);
            chk("reset value", 8'h00, rd);
        end
        $display("test reset values done");

        repeat (20)
        begin
            v = 8'(rnd());
            @(posedge mclk);
            pin_level <= 8'(rnd());
            bus(1'b1, CMPIS_OFF_DID, v, 4'hf);
            bus(1'b1, CMPIS_OFF_DID, ~v, 4'h0);
            bus(1'b1, 5'h18, 8'hff, 4'hf);
            bus(1'b0, 5'h18, 8'h00, 4'hf);
            chk("unmapped read", 8'h00, rd);
            @(negedge mclk);
            chk("buffer_disable", v, buffer_disable);
            chk("port_read", pin_level & ~v, port_read);
        end
        bus(1'b1, CMPIS_OFF_DID, 8'h00, 4'hf);
        $display("test input disable done");

        bus(1'b1, CMPIS_OFF_CSB, 8'h40, 4'hf);
        for (int c = 0; c < 32; c++)
        begin
            v = 8'(rnd());
            @(posedge mclk);
            converter_enable <= v[0];
            bus(1'b1, CMPIS_OFF_MUX, 8'(c), 4'hf);
            @(negedge mclk);
            chk("pos from_pin", {7'h0, v[0]}, {7'h0, pos_sel.from_pin});
            if (!v[0])
            begin
                chk("pos valid", {7'h0, 5'(c) <= CMPIS_CHAN_MAX},
                    {7'h0, pos_sel.chan_valid});
                if (5'(c) <= CMPIS_CHAN_MAX)
                    chk("pos chan", 8'(c), {3'h0, pos_sel.chan});
            end
        end
        bus(1'b1, CMPIS_OFF_CSB, 8'h00, 4'hf);
        @(negedge mclk);
        chk("pos pin", 8'h01, {7'h0, pos_sel.from_pin});
        $display("test positive input done");

        for (int i = 0; i < 32; i++)
        begin
            bus(1'b1, CMPIS_OFF_CTRL, {1'b0, i[4], 6'h00}, 4'hf);
            bus(1'b1, CMPIS_OFF_CSB, {2'h0, i[3:2], 4'h0}, 4'hf);
            bus(1'b1, CMPIS_OFF_MUX, {i[1:0], 6'h00}, 4'hf);
            @(negedge mclk);
            chk("neg from_pin", {7'h0, !i[4]}, {7'h0, neg_sel.from_pin});
            if (i[4])
                chk("neg ref", {5'h0, i[1:0] == CMPIS_REFS_INT, i[3:2]},
                    {5'h0, neg_sel.ref_ok, neg_sel.div});
        end
        $display("test negative input done");

        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, CMPIS_OFF_CTRL, {6'h04, 2'(m)}, 4'hf);
            for (int e = 1; e >= 0; e--)
            begin
                @(posedge mclk);
                cmp_raw <= e[0];
                repeat (5) @(posedge mclk);
                bus(1'b0, CMPIS_OFF_CTRL, 8'h00, 4'hf);
                chk("output status", {7'h0, e[0]}, {7'h0, rd[CMPIS_CS_OUT]});
                chk("irq flag", {7'h0, exp_flag(2'(m), e[0])}, {7'h0, rd[CMPIS_CS_FLAG]});
                bus(1'b1, CMPIS_OFF_CTRL, {6'h04, 2'(m)}, 4'hf);
                bus(1'b0, CMPIS_OFF_CTRL, 8'h00, 4'hf);
                chk("flag cleared", 8'h00, {7'h0, rd[CMPIS_CS_FLAG]});
            end
        end
        $display("test event modes done");

        bus(1'b1, CMPIS_OFF_CTRL, 8'h10, 4'hf);
        bus(1'b1, CMPIS_OFF_CTRL, 8'h08, 4'hf);
        @(posedge mclk);
        cmp_raw <= 1'b1;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk("req global off", 8'h00, {7'h0, comparator_irq_req});
        @(posedge mclk);
        global_irq_enable <= 1'b1;
        @(negedge mclk);
        chk("req global on", 8'h01, {7'h0, comparator_irq_req});
        @(posedge mclk);
        vector_ack <= 1'b1;
        @(posedge mclk);
        vector_ack <= 1'b0;
        @(negedge mclk);
        chk("req after vector", 8'h00, {7'h0, comparator_irq_req});
        $display("test interrupt request done");

        bus(1'b0, CMPIS_OFF_STAT, 8'h00, 4'hf);
        // comparator, bad reference and bad channel events all happened above
        chk("early status", 8'h07, rd);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, CMPIS_OFF_MASK, {7'h0, !k[0]}, 4'hf);
            @(posedge mclk);
            cmp_raw <= k[0];
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk("irq line", {7'h0, !k[0]}, {7'h0, irq});
            bus(1'b0, CMPIS_OFF_STAT, 8'h00, 4'hf);
            chk("event status", 8'h01, rd & 8'h01);
            @(negedge mclk);
            chk("irq after read", 8'h00, {7'h0, irq});
        end
        $display("test status and mask done");
        wrap_up();
    end
endmodule : cmpis_tb_top
